// [lockup_sleep_pkg.sv]
package lockup_sleep_pkg;

  // Halfword-aligned fetch address used for the whole time the core is locked up
  localparam logic [31:0] LOCKUP_ADDR    = 32'hffff_fffe;

  // Register byte offsets
  localparam logic [7:0]  REG_RESET_CTRL = 8'h00;
  localparam logic [7:0]  REG_SLEEP_CTRL = 8'h04;
  localparam logic [7:0]  REG_STATUS     = 8'h08;

  // Field positions
  localparam int          RESET_REQ_POS  = 2;
  localparam int          SLEEP_EXIT_POS = 1;
  localparam int          DEEP_SEL_POS   = 2;
  localparam int          WAKE_PEND_POS  = 4;
  localparam int          ST_LOCK_POS    = 0;
  localparam int          ST_NEG2_POS    = 1;
  localparam int          ST_SLEEP_POS   = 2;
  localparam int          ST_EVENT_POS   = 3;
  localparam int          ST_DEEP_POS    = 4;

  // Reset values
  localparam logic        CTRL_BIT_RST   = 1'b0;
  localparam logic [31:0] DATA_RST       = 32'h0000_0000;

  typedef enum logic [1:0] {
    PRI_NORMAL = 2'h0,
    PRI_NEG1   = 2'h1,
    PRI_NEG2   = 2'h2
  } exec_pri_e;

  typedef enum logic [3:0] {
    CAUSE_VEC_RESET = 4'h0,
    CAUSE_VEC_NMI   = 4'h1,
    CAUSE_VEC_FATAL = 4'h2,
    CAUSE_FETCH     = 4'h3,
    CAUSE_PRECISE   = 4'h4,
    CAUSE_IMPRECISE = 4'h5,
    CAUSE_STK_NMI   = 4'h6,
    CAUSE_UNSTK     = 4'h7,
    CAUSE_SVC       = 4'h8,
    CAUSE_USAGE     = 4'h9,
    CAUSE_UNDEF     = 4'ha,
    CAUSE_BREAKPOINT_INSTRUCTION      = 4'hb
  } fault_cause_e;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b001,
    ST_LOCKED = 3'b010,
    ST_SLEEP  = 3'b100
  } core_state_e;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } wb_req_s;

  typedef struct packed {
    logic         valid;
    fault_cause_e cause;
    exec_pri_e    pri;
  } fault_s;

  typedef struct packed {
    logic wait_interrupt_hint;
    logic wait_event_hint;
    logic exc_return;
    logic no_other_active;
  } hint_s;

  typedef struct packed {
    logic async_exc;
    logic pend_rise;
    logic sev;
    logic debug_event;
  } wake_s;

endpackage

// [lockup_reset_sleep_control.sv]
// Functional notes
// - A fault or supervisor call at priority -1 or higher locks up, no normal entry.
// - Locked core fetches repeatedly from the fixed halfword-aligned lockup address.
// - Lockup address is never-execute, so each fetch there relocks the core.
// - An external output shows that the core is locked up.
// - Locked at -1, an NMI activates normally with lockup address as return link.
// - System reset leaves lockup and resets everything normally.
// - Debug halt during lockup enters debug state with PC at lockup address.
// - Vector read error for reset SP or PC locks up at priority -1.
// - Vector read error on NMI entry locks up at priority -2.
// - Vector read error on fatal-fault entry locks up at priority -1.
// - Fetch, data, usage, undefined and non-debug breakpoint faults lock at current priority.
// - Stacking error on NMI entry from -1 locks at -1 or -2, a chosen option.
// - Unstacking error locks at -1 or -2 or raises fatal fault per restored state.
// - Supervisor call at -1 or -2 acts as undefined and locks at current priority.
// - Writing 1 to the reset request bit asks outside logic for a system reset.
// - The requested reset may arrive some cycles after the write.
// - Wait hints may act as no-operations; sleeping is optional.
// - Wait-for-interrupt may suspend execution until a wakeup event.
// - With wake-on-pend set, any new pending interrupt wakes a wait-for-event sleep.
// - Sleep-on-exit suspends on a return leaving no active exception.
// - Sleep-on-exit wakes on exactly the wait-for-interrupt wakeup events.
// - Deep-sleep bit at 1 signals slower wakeup so clocks may be stopped.
// - Wait-for-event with event flag set clears it and continues at once.
// - Wait-for-interrupt sleep ends on an unmasked-preempting exception or reset.
//
// Decided for this implementation: the Wishbone interface to the registers and the address map.
module lockup_reset_sleep_control #(
  parameter logic SLEEP_EN         = 1'b1,
  parameter logic STK_NMI_LOCK_NEG2 = 1'b0
) (
  input  logic                          clk_i,
  input  logic                          rst_i,
  input  lockup_sleep_pkg::wb_req_s     wb_i,
  output logic                          wb_ack_o,
  output logic [31:0]                   wb_dat_o,
  input  lockup_sleep_pkg::fault_s      fault_i,
  input  logic                          debug_enable_i,
  input  logic                          unstack_lock_i,
  input  logic                          unstack_neg2_i,
  input  logic                          nmi_i,
  input  logic                          halt_req_i,
  input  lockup_sleep_pkg::hint_s       hint_i,
  input  lockup_sleep_pkg::wake_s       wake_i,
  output logic                          lockup_o,
  output logic                          lockup_neg2_o,
  output logic [31:0]                   fetch_addr_o,
  output logic [31:0]                   return_link_o,
  output logic                          nmi_take_o,
  output logic                          debug_halt_o,
  output logic                          fatal_take_o,
  output logic                          hint_done_o,
  output logic                          sys_reset_req_o,
  output logic                          sleeping_o,
  output logic                          deep_sleep_o
);
  import lockup_sleep_pkg::*;

  core_state_e state;
  core_state_e next_state;
  logic        sleep_exit_bit;
  logic        deep_bit;
  logic        wake_pend_bit;
  logic        event_flag;
  logic        sleep_wfe;
  logic        lock_hit;
  logic        lock_neg2;
  logic        fatal_hit;
  logic        next_neg2;
  logic        next_sleep_wfe;
  logic        next_nmi_take;
  logic        next_halt;
  logic        next_fatal;
  logic        next_done;

  // Register bus decode
  wire         bus_req    = wb_i.cyc & wb_i.stb & ~wb_ack_o;
  wire         wr_en      = bus_req & wb_i.we & wb_i.sel[0];
  wire         hit_reset  = wb_i.adr == REG_RESET_CTRL;
  wire         hit_sleep  = wb_i.adr == REG_SLEEP_CTRL;
  wire         hit_status = wb_i.adr == REG_STATUS;
  wire         wr_reset   = wr_en & hit_reset & wb_i.dat[RESET_REQ_POS];
  wire         wr_sleep   = wr_en & hit_sleep;

  logic [31:0] rd_reset;
  logic [31:0] rd_sleep;
  logic [31:0] rd_status;
  always_comb begin
    rd_reset                 = DATA_RST;
    rd_reset[RESET_REQ_POS]  = sys_reset_req_o;
    rd_sleep                 = DATA_RST;
    rd_sleep[SLEEP_EXIT_POS] = sleep_exit_bit;
    rd_sleep[DEEP_SEL_POS]   = deep_bit;
    rd_sleep[WAKE_PEND_POS]  = wake_pend_bit;
    rd_status                = DATA_RST;
    rd_status[ST_LOCK_POS]   = lockup_o;
    rd_status[ST_NEG2_POS]   = lockup_neg2_o;
    rd_status[ST_SLEEP_POS]  = sleeping_o;
    rd_status[ST_EVENT_POS]  = event_flag;
    rd_status[ST_DEEP_POS]   = deep_sleep_o;
  end

  wire [31:0]  rd_data = hit_reset  ? rd_reset  :
                         hit_sleep  ? rd_sleep  :
                         hit_status ? rd_status : DATA_RST;

  // Fault classification
  wire         elevated = fault_i.pri != PRI_NORMAL;
  wire         cur_neg2 = fault_i.pri == PRI_NEG2;

  always_comb begin
    lock_hit  = 1'b0;
    lock_neg2 = 1'b0;
    fatal_hit = 1'b0;
    unique case (fault_i.cause)
      CAUSE_VEC_RESET, CAUSE_VEC_FATAL: begin
        lock_hit = 1'b1;
      end
      CAUSE_VEC_NMI: begin
        lock_hit  = 1'b1;
        lock_neg2 = 1'b1;
      end
      CAUSE_STK_NMI: begin
        lock_hit  = 1'b1;
        lock_neg2 = STK_NMI_LOCK_NEG2;
      end
      CAUSE_UNSTK: begin
        lock_hit  = unstack_lock_i;
        lock_neg2 = unstack_neg2_i;
        fatal_hit = ~unstack_lock_i;
      end
      CAUSE_SVC: begin
        lock_hit  = elevated;
        lock_neg2 = cur_neg2;
      end
      CAUSE_BREAKPOINT_INSTRUCTION: begin
        lock_hit  = elevated & ~debug_enable_i;
        lock_neg2 = cur_neg2;
        fatal_hit = ~elevated & ~debug_enable_i;
      end
      default: begin
        lock_hit  = elevated;
        lock_neg2 = cur_neg2;
        fatal_hit = ~elevated;
      end
    endcase
  end

  wire         lock_take  = fault_i.valid & lock_hit;
  wire         fatal_take = fault_i.valid & fatal_hit;

  // Wakeup sets
  wire         wake_wfi   = wake_i.async_exc | (debug_enable_i & wake_i.debug_event);
  wire         wake_wfe   = wake_wfi | wake_i.sev | (wake_pend_bit & wake_i.pend_rise);
  wire         wake_now   = sleep_wfe ? wake_wfe : wake_wfi;
  wire         exit_sleep = hint_i.exc_return & hint_i.no_other_active & sleep_exit_bit;
  wire         xn_hit     = lockup_o & (fetch_addr_o[31:1] == LOCKUP_ADDR[31:1]);
  wire         run_wfe    = (state == ST_RUN) & hint_i.wait_event_hint;

  always_comb begin
    next_state     = state;
    next_neg2      = lockup_neg2_o;
    next_sleep_wfe = sleep_wfe;
    next_nmi_take  = 1'b0;
    next_halt      = 1'b0;
    next_fatal     = 1'b0;
    next_done      = 1'b0;
    unique case (state)
      ST_RUN: begin
        if (lock_take) begin
          next_state = ST_LOCKED;
          next_neg2  = lock_neg2;
        end else if (fatal_take) begin
          next_fatal = 1'b1;
        end else if (SLEEP_EN && (hint_i.wait_interrupt_hint || exit_sleep)) begin
          next_state     = ST_SLEEP;
          next_sleep_wfe = 1'b0;
        end else if (hint_i.wait_event_hint && !event_flag && SLEEP_EN) begin
          next_state     = ST_SLEEP;
          next_sleep_wfe = 1'b1;
        end else if (hint_i.wait_interrupt_hint || hint_i.wait_event_hint) begin
          next_done = 1'b1;
        end
      end
      ST_LOCKED: begin
        if (halt_req_i) begin
          next_state = ST_RUN;
          next_halt  = 1'b1;
          next_neg2  = 1'b0;
        end else if (nmi_i && !lockup_neg2_o) begin
          next_state    = ST_RUN;
          next_nmi_take = 1'b1;
        end else if (xn_hit) begin
          next_state = ST_LOCKED;
        end
      end
      ST_SLEEP: begin
        if (wake_now) begin
          next_state = ST_RUN;
          next_done  = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state     <= ST_RUN;
      sleep_wfe <= 1'b0;
    end else begin
      state     <= next_state;
      sleep_wfe <= next_sleep_wfe;
    end
  end

  // Lockup indication and fetch address
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lockup_o      <= 1'b0;
      lockup_neg2_o <= 1'b0;
      fetch_addr_o  <= DATA_RST;
    end else begin
      lockup_o      <= next_state == ST_LOCKED;
      lockup_neg2_o <= next_neg2;
      fetch_addr_o  <= (next_state == ST_LOCKED) ? LOCKUP_ADDR : DATA_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_take_o    <= 1'b0;
      debug_halt_o  <= 1'b0;
      fatal_take_o  <= 1'b0;
      hint_done_o   <= 1'b0;
      return_link_o <= DATA_RST;
    end else begin
      nmi_take_o    <= next_nmi_take;
      debug_halt_o  <= next_halt;
      fatal_take_o  <= next_fatal;
      hint_done_o   <= next_done;
      if (next_nmi_take || next_halt) begin
        return_link_o <= LOCKUP_ADDR;
      end
    end
  end

  // Sleep outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sleeping_o   <= 1'b0;
      deep_sleep_o <= 1'b0;
    end else begin
      sleeping_o   <= next_state == ST_SLEEP;
      deep_sleep_o <= (next_state == ST_SLEEP) & deep_bit;
    end
  end

  // Event flag: a new event wins over the clear by a wait-for-event hint
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_flag <= 1'b0;
    end else begin
      event_flag <= (event_flag & ~run_wfe) | wake_wfe | hint_i.exc_return;
    end
  end

  // Registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sys_reset_req_o <= CTRL_BIT_RST;
      sleep_exit_bit  <= CTRL_BIT_RST;
      deep_bit        <= CTRL_BIT_RST;
      wake_pend_bit   <= CTRL_BIT_RST;
    end else begin
      if (wr_reset) begin
        sys_reset_req_o <= 1'b1;
      end
      if (wr_sleep) begin
        sleep_exit_bit <= wb_i.dat[SLEEP_EXIT_POS];
        deep_bit       <= wb_i.dat[DEEP_SEL_POS];
        wake_pend_bit  <= wb_i.dat[WAKE_PEND_POS];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= DATA_RST;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= (bus_req & ~wb_i.we) ? rd_data : DATA_RST;
    end
  end

  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_undef_lock;
    (state == ST_RUN) && fault_i.valid && (fault_i.cause == CAUSE_UNDEF) && elevated
      |=> lockup_o && (lockup_neg2_o == $past(cur_neg2)) && (fetch_addr_o == LOCKUP_ADDR);
  endproperty
  a_undef_lock: assert property (p_undef_lock) else $error("undefined fault did not lock");

  property p_vec_nmi;
    (state == ST_RUN) && fault_i.valid && (fault_i.cause == CAUSE_VEC_NMI)
      |=> lockup_o && lockup_neg2_o;
  endproperty
  a_vec_nmi: assert property (p_vec_nmi) else $error("nmi vector error not at -2");

  property p_vec_reset;
    (state == ST_RUN) && fault_i.valid && (fault_i.cause == CAUSE_VEC_RESET)
      |=> lockup_o && !lockup_neg2_o;
  endproperty
  a_vec_reset: assert property (p_vec_reset) else $error("reset vector error not at -1");

  property p_stay_locked;
    lockup_o && !halt_req_i && !(nmi_i && !lockup_neg2_o)
      |=> lockup_o && (fetch_addr_o[31:1] == LOCKUP_ADDR[31:1]);
  endproperty
  a_stay_locked: assert property (p_stay_locked) else $error("lockup left without cause");

  property p_nmi_exit;
    lockup_o && !lockup_neg2_o && nmi_i && !halt_req_i
      |=> nmi_take_o && !lockup_o && (return_link_o == LOCKUP_ADDR) ##1 !nmi_take_o;
  endproperty
  a_nmi_exit: assert property (p_nmi_exit) else $error("nmi did not leave lockup");

  property p_halt_exit;
    lockup_o && halt_req_i |=> debug_halt_o && !lockup_o && (return_link_o == LOCKUP_ADDR);
  endproperty
  a_halt_exit: assert property (p_halt_exit) else $error("halt did not leave lockup");

  property p_reset_req;
    wr_reset |=> sys_reset_req_o [*3];
  endproperty
  a_reset_req: assert property (p_reset_req) else $error("reset request not held");

  property p_wfe_skip;
    run_wfe && event_flag && !fault_i.valid && !hint_i.wait_interrupt_hint && !exit_sleep
      |=> hint_done_o && !sleeping_o;
  endproperty
  a_wfe_skip: assert property (p_wfe_skip) else $error("wfe slept with event set");

  property p_exit_sleep;
    (state == ST_RUN) && exit_sleep && !fault_i.valid |=> sleeping_o && !sleep_wfe;
  endproperty
  a_exit_sleep: assert property (p_exit_sleep) else $error("sleep-on-exit missed");

  property p_wfi_wake;
    sleeping_o && !sleep_wfe && wake_i.async_exc |=> !sleeping_o && hint_done_o;
  endproperty
  a_wfi_wake: assert property (p_wfi_wake) else $error("sleep not woken");

  property p_deep;
    sleeping_o |-> deep_sleep_o == $past(deep_bit);
  endproperty
  a_deep: assert property (p_deep) else $error("deep sleep output wrong");

  c_lockup: cover property ($rose(lockup_o));
  c_nmi:    cover property (nmi_take_o);
  c_sleep:  cover property ($rose(sleeping_o) ##[1:20] $fell(sleeping_o));
  c_reset:  cover property ($rose(sys_reset_req_o));

endmodule // lockup_reset_sleep_control

// [reset_power_partner.sv]
module reset_power_partner #(
  parameter int DELAY = 4
) (
  input  logic clk_i,
  input  logic por_i,
  input  logic sys_reset_req_i,
  input  logic deep_sleep_i,
  output logic rst_o,
  output logic clk_gate_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] wait_cnt;
  logic       fire;

  // The requested reset lands some cycles after the request, not on the writing edge
  always_ff @(posedge clk_i) begin
    if (por_i || fire) begin
      wait_cnt <= 8'h00;
      fire     <= 1'b0;
    end else if (sys_reset_req_i) begin
      wait_cnt <= wait_cnt + 8'h01;
      fire     <= (wait_cnt == 8'(DELAY));
    end
  end

  // One reset for the whole system, core included
  assign rst_o = por_i | fire;

  // Deep sleep lets the clock source be stopped
  always_ff @(posedge clk_i) begin
    clk_gate_o <= deep_sleep_i & ~por_i;
  end
endmodule // reset_power_partner

// [lockup_reset_sleep_control_tb_top.sv]
module lockup_reset_sleep_control_tb_top import lockup_sleep_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct packed {
    fault_cause_e c;
    exec_pri_e    p;
    logic [5:0]   f;
  } case_s;

  logic        clk_i;
  logic        por;
  logic        rst_i;
  wb_req_s     wb_i;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  fault_s      fault_i;
  logic        debug_enable_i;
  logic        unstack_lock_i;
  logic        unstack_neg2_i;
  logic        nmi_i;
  logic        halt_req_i;
  hint_s       hint_i;
  wake_s       wake_i;
  logic        lockup_o;
  logic        lockup_neg2_o;
  logic [31:0] fetch_addr_o;
  logic [31:0] return_link_o;
  logic        nmi_take_o;
  logic        debug_halt_o;
  logic        fatal_take_o;
  logic        hint_done_o;
  logic        sys_reset_req_o;
  logic        sleeping_o;
  logic        deep_sleep_o;
  int          failures;
  int          checks;
  // Flags: debug enable, unstack lock, unstack -2, locks, -2, fatal taken
  case_s       tbl [16] = '{
    '{CAUSE_VEC_RESET, PRI_NORMAL, 6'b000100}, '{CAUSE_VEC_NMI, PRI_NORMAL, 6'b000110},
    '{CAUSE_VEC_FATAL, PRI_NEG2, 6'b000100}, '{CAUSE_FETCH, PRI_NEG1, 6'b000100},
    '{CAUSE_PRECISE, PRI_NEG2, 6'b000110}, '{CAUSE_IMPRECISE, PRI_NEG1, 6'b000100},
    '{CAUSE_USAGE, PRI_NEG2, 6'b000110}, '{CAUSE_UNDEF, PRI_NEG1, 6'b000100},
    '{CAUSE_BREAKPOINT_INSTRUCTION, PRI_NEG2, 6'b000110}, '{CAUSE_BREAKPOINT_INSTRUCTION, PRI_NEG1, 6'b100000},
    '{CAUSE_SVC, PRI_NEG2, 6'b000110}, '{CAUSE_SVC, PRI_NORMAL, 6'b000000},
    '{CAUSE_UNDEF, PRI_NORMAL, 6'b000001}, '{CAUSE_STK_NMI, PRI_NEG1, 6'b000100},
    '{CAUSE_UNSTK, PRI_NEG1, 6'b011110}, '{CAUSE_UNSTK, PRI_NEG2, 6'b000001}};

  lockup_reset_sleep_control #(.SLEEP_EN(1'b1), .STK_NMI_LOCK_NEG2(1'b0)) uut (
    .clk_i, .rst_i, .wb_i, .wb_ack_o, .wb_dat_o, .fault_i, .debug_enable_i,
    .unstack_lock_i, .unstack_neg2_i, .nmi_i, .halt_req_i, .hint_i, .wake_i,
    .lockup_o, .lockup_neg2_o, .fetch_addr_o, .return_link_o, .nmi_take_o,
    .debug_halt_o, .fatal_take_o, .hint_done_o, .sys_reset_req_o, .sleeping_o,
    .deep_sleep_o);

  reset_power_partner #(.DELAY(4)) far_end (
    .clk_i(clk_i), .por_i(por), .sys_reset_req_i(sys_reset_req_o),
    .deep_sleep_i(deep_sleep_o), .rst_o(rst_i), .clk_gate_o());

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Classic cycle: hold until ack is sampled high, then release for a cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
    int n;
    wb_i <= '{1'b1, 1'b1, we, a, s, d};
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    q = wb_dat_o;
    wb_i <= '0;
    if (n == 20) begin
      failures++;
      complete_run();
    end
    tick(1);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] q;
    bus(1'b1, a, d, s, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(q, exp);
  endtask

  task automatic fault(input fault_cause_e c, input exec_pri_e p);
    fault_i <= '{1'b1, c, p};
    tick(1);
    fault_i.valid <= 1'b0;
    tick(1);
  endtask

  task automatic ctl(input logic n, input logic h);
    nmi_i      <= n;
    halt_req_i <= h;
    tick(1);
    nmi_i      <= 1'b0;
    halt_req_i <= 1'b0;
    tick(1);
  endtask

  task automatic hint(input hint_s h);
    hint_i <= h;
    tick(1);
    hint_i <= '0;
    tick(1);
  endtask

  task automatic wake(input wake_s w);
    wake_i <= w;
    tick(1);
    wake_i <= '0;
    tick(1);
  endtask

  initial begin
    int n;
    por = 1'b1;
    {wb_i, fault_i, hint_i, wake_i} = '0;
    {debug_enable_i, unstack_lock_i, unstack_neg2_i, nmi_i, halt_req_i} = '0;
    failures = 0;
    checks = 0;
    tick(2);
    por <= 1'b0;
    tick(1);
    rd(REG_STATUS, 32'h0);
    wr(REG_SLEEP_CTRL, 32'h16, 4'he);
    rd(REG_SLEEP_CTRL, 32'h0);
    wr(8'hfc, 32'hff, 4'hf);
    rd(8'hfc, 32'h0);
    fault(CAUSE_UNDEF, PRI_NEG1);
    chk(return_link_o, 32'h0);
    ctl(1'b1, 1'b0);
    chk({lockup_o, nmi_take_o}, 32'h1);
    chk(return_link_o, LOCKUP_ADDR);
    fault(CAUSE_PRECISE, PRI_NEG2);
    rd(REG_STATUS, 32'h3);
    ctl(1'b1, 1'b0);
    chk({lockup_o, nmi_take_o}, 32'h2);
    ctl(1'b1, 1'b1);
    chk({lockup_o, debug_halt_o, nmi_take_o}, 32'h2);
    foreach (tbl[i]) begin
      debug_enable_i <= tbl[i].f[5];
      unstack_lock_i <= tbl[i].f[4];
      unstack_neg2_i <= tbl[i].f[3];
      fault(tbl[i].c, tbl[i].p);
      chk({lockup_o, lockup_neg2_o, fatal_take_o}, 32'(tbl[i].f[2:0]));
      chk(fetch_addr_o, tbl[i].f[2] ? LOCKUP_ADDR : 32'h0);
      tick(3);
      chk(fetch_addr_o, tbl[i].f[2] ? LOCKUP_ADDR : 32'h0);
      if (tbl[i].f[2]) begin
        ctl(1'b0, 1'b1);
        chk({lockup_o, debug_halt_o}, 32'h1);
        chk(return_link_o, LOCKUP_ADDR);
      end
    end
    debug_enable_i <= 1'b1;
    hint('{1'b1, 1'b0, 1'b0, 1'b0});
    chk({sleeping_o, deep_sleep_o}, 32'h2);
    wake('{1'b0, 1'b0, 1'b1, 1'b0});
    chk(sleeping_o, 32'h1);
    wake('{1'b1, 1'b0, 1'b0, 1'b0});
    chk({sleeping_o, hint_done_o}, 32'h1);
    hint('{1'b0, 1'b1, 1'b0, 1'b0});
    chk({sleeping_o, hint_done_o}, 32'h1);
    hint('{1'b0, 1'b1, 1'b0, 1'b0});
    chk(sleeping_o, 32'h1);
    wake('{1'b0, 1'b1, 1'b0, 1'b0});
    chk(sleeping_o, 32'h1);
    wr(REG_SLEEP_CTRL, 32'h1 << WAKE_PEND_POS, 4'h1);
    wake('{1'b0, 1'b1, 1'b0, 1'b0});
    chk({sleeping_o, hint_done_o}, 32'h1);
    wr(REG_SLEEP_CTRL, (32'h1 << SLEEP_EXIT_POS) | (32'h1 << DEEP_SEL_POS), 4'h1);
    rd(REG_SLEEP_CTRL, 32'h6);
    hint('{1'b0, 1'b0, 1'b1, 1'b0});
    chk(sleeping_o, 32'h0);
    hint('{1'b0, 1'b0, 1'b1, 1'b1});
    chk({sleeping_o, deep_sleep_o}, 32'h3);
    wake('{1'b0, 1'b0, 1'b1, 1'b0});
    rd(REG_STATUS, 32'h1c);
    wake('{1'b0, 1'b0, 1'b0, 1'b1});
    chk({sleeping_o, deep_sleep_o, hint_done_o}, 32'h1);
    fault(CAUSE_UNDEF, PRI_NEG1);
    wr(REG_RESET_CTRL, 32'h0, 4'h1);
    chk(sys_reset_req_o, 32'h0);
    wr(REG_RESET_CTRL, 32'h1 << RESET_REQ_POS, 4'h1);
    chk({sys_reset_req_o, lockup_o}, 32'h3);
    for (n = 0; n < 20 && rst_i !== 1'b1; n++) tick(1);
    if (n == 20) begin
      failures++;
      complete_run();
    end
    tick(2);
    chk({sys_reset_req_o, lockup_o}, 32'h0);
    chk(fetch_addr_o, 32'h0);
    rd(REG_SLEEP_CTRL, 32'h0);
    complete_run();
  end
endmodule // lockup_reset_sleep_control_tb_top
